// ===== design/otpc_config_loader.sv
// Power-up mode latch, dual-bank fuse store, test-write shifter and decoded
// configuration with the fast pulse stream and its three output dividers.
// Assumes rst_n_i is the power-on reset; fuse cells survive it.
//
// Functional notes
// - At every power-up the fuses are read and the active bank used.
// - Two full banks; bank choice bit picks bank 0 or bank 1.
// - Mode latched only at power-up: select 0 normal, 1 with clock low programming.
// - Programming mode holds until power is removed.
// - Undriven mode select gives normal metering.
// - Motor, calibration and indicator pulses still run in programming mode.
// - Program data pin carries test-write data and burn data.
// - Test-write loads a volatile register and the device runs from it.
// - Burn sets selected fuse cells permanently.
// - Gain code 00 gives 4, 01/10 give 16, 11 gives 20; default 11.
// - Anti-creep code selects one of four thresholds; default 01.
// - Motor rate code selects 100 to 800 impulses; default 10.
// - Calibration multiplier 8 to 64 on motor rate; default 01.
// - Indicator rate code selects 100 to 6400 impulses; default 101.
// - Fast pulse when accumulator exceeds the 22-bit threshold.
// - All output rates divide down the one fast pulse stream.
// - Hard defaults apply unless the use-programmed bit is set.
// - Test-write: mode falls then rises, then 70 shift clocks on rising edges.
// - Test-written word lives only in volatile storage.
`timescale 1ns/1ps
module otpc_config_loader #(
    parameter int ENERGY_W = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic fuse_blank_n_i,
    input wire logic power_up_mode_select_i,
    input wire logic direction_out_shift_clock_i,
    input wire logic program_data_pin_i,
    input wire logic burn_strobe_i,
    input wire logic energy_valid_i,
    input wire logic [ENERGY_W-1:0] energy_inc_i,
    output logic program_data_pin_mode_o,
    output logic cfg_valid_o,
    output logic [4:0] gain_o,
    output logic [1:0] creep_sel_o,
    output logic [12:0] mon_rate_o,
    output logic [6:0] cal_mult_o,
    output logic [12:0] led_rate_o,
    output logic [21:0] pulse_lev_o,
    output logic fast_pulse_o,
    output logic motor_drive_outputs_o,
    output logic cal_pulse_o,
    output logic led_pulse_o
);
    if (ENERGY_W < 1 || ENERGY_W > 22) begin : g_bad_width
        $error("ENERGY_W must be 1 to 22");
    end

    ////////////////////////////////////////////////////////////////////////
    otpc_pin_if #(.N(otpc_pkg::PIN_N)) pins ();
    assign pins.raw = {burn_strobe_i, program_data_pin_i,
                       direction_out_shift_clock_i, power_up_mode_select_i};
    otpc_pin_sync #(.N(otpc_pkg::PIN_N)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .pins(pins)
    );

    ////////////////////////////////////////////////////////////////////////
    otpc_pkg::otpc_state_e state_q, state_d;
    logic [6:0] cnt_q, cnt_d;
    logic [69:0] shift_q, shift_d;
    logic [69:0] word_q, word_d;
    logic [69:0] fuse_q, fuse_d;
    logic load_q, load_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        word_d = word_q;
        fuse_d = fuse_q;
        load_d = 1'b0;
        case (state_q)
            otpc_pkg::ST_SETTLE: begin
                cnt_d = cnt_q + 7'h01;
                if (cnt_q[2:0] == otpc_pkg::SETTLE_CYC) begin
                    state_d = otpc_pkg::ST_READ;
                end
            end
            otpc_pkg::ST_READ: begin
                word_d = fuse_q;
                load_d = 1'b1;
                cnt_d = 7'h00;
                // Pull-down makes an open pin read 0, i.e. normal
                if (pins.lvl[otpc_pkg::PIN_MODE] && !pins.lvl[otpc_pkg::PIN_SCLK]) begin
                    state_d = otpc_pkg::ST_PROGRAM_DATA_PIN_IDLE;
                end else begin
                    state_d = otpc_pkg::ST_NORMAL;
                end
            end
            otpc_pkg::ST_NORMAL: begin
                state_d = otpc_pkg::ST_NORMAL;
            end
            otpc_pkg::ST_PROGRAM_DATA_PIN_IDLE: begin
                if (pins.fall[otpc_pkg::PIN_MODE]) begin
                    state_d = otpc_pkg::ST_TW_ARMED;
                end else if (pins.rise[otpc_pkg::PIN_BURN]) begin
                    // Ones of the true word blow cells; only the factory blank input clears one
                    fuse_d = fuse_q | ~shift_q;
                end
            end
            otpc_pkg::ST_TW_ARMED: begin
                if (pins.rise[otpc_pkg::PIN_MODE]) begin
                    state_d = otpc_pkg::ST_TW_SHIFT;
                    cnt_d = 7'h00;
                end
            end
            otpc_pkg::ST_TW_SHIFT: begin
                if (pins.rise[otpc_pkg::PIN_SCLK]) begin
                    // First bit shifted ends up at bit 69
                    shift_d = {shift_q[68:0], pins.lvl[otpc_pkg::PIN_DATA]};
                    cnt_d = cnt_q + 7'h01;
                    if (cnt_q == otpc_pkg::SHIFT_LAST) begin
                        word_d = ~shift_d;
                        load_d = 1'b1;
                        state_d = otpc_pkg::ST_PROGRAM_DATA_PIN_IDLE;
                    end
                end
            end
            default: begin
                state_d = otpc_pkg::ST_SETTLE;
            end
        endcase
        if (!fuse_blank_n_i) begin
            fuse_d = '0;
        end
    end

    // Word and shifter reset at power-up, so a test-write is lost with supply
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_q <= otpc_pkg::ST_SETTLE;
            cnt_q <= 7'h00;
            shift_q <= otpc_pkg::SHIFT_RST;
            word_q <= '0;
            load_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            word_q <= word_d;
            load_q <= load_d;
        end
    end

    // Fuses ignore the power-on reset; only the factory blank input clears them
    always_ff @(posedge sys_clk_i) begin
        fuse_q <= fuse_d;
    end

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] f_gain, f_creep, f_mon, f_cal;
    logic [2:0] f_led, led_code;
    logic [21:0] f_lev;
    logic [4:0] gain_d;
    logic [3:0] sh_d [3];
    logic [3:0] sh_q [3];
    logic cfg_valid_q;

    always_comb begin
        if (!word_q[otpc_pkg::SEL_BIT]) begin
            f_gain = otpc_pkg::DEF_GAIN;
            f_creep = otpc_pkg::DEF_CREEP;
            f_mon = otpc_pkg::DEF_MON;
            f_cal = otpc_pkg::DEF_CAL;
            f_led = otpc_pkg::DEF_LED;
            f_lev = otpc_pkg::DEF_LEV;
        end else if (word_q[otpc_pkg::BANK_BIT]) begin
            f_gain = word_q[otpc_pkg::B1_GAIN_LSB +: 2];
            f_creep = word_q[otpc_pkg::B1_CREEP_LSB +: 2];
            f_mon = word_q[otpc_pkg::B1_MON_LSB +: 2];
            f_cal = word_q[otpc_pkg::B1_CAL_LSB +: 2];
            f_led = word_q[otpc_pkg::B1_LED_LSB +: 3];
            f_lev = word_q[otpc_pkg::B1_LEV_LSB +: otpc_pkg::LEV_W];
        end else begin
            f_gain = word_q[otpc_pkg::B0_GAIN_LSB +: 2];
            f_creep = word_q[otpc_pkg::B0_CREEP_LSB +: 2];
            f_mon = word_q[otpc_pkg::B0_MON_LSB +: 2];
            f_cal = word_q[otpc_pkg::B0_CAL_LSB +: 2];
            f_led = word_q[otpc_pkg::B0_LED_LSB +: 3];
            f_lev = word_q[otpc_pkg::B0_LEV_LSB +: otpc_pkg::LEV_W];
        end
        case (f_gain)
            2'h0: gain_d = otpc_pkg::GAIN_LOW;
            2'h1: gain_d = otpc_pkg::GAIN_MID;
            2'h2: gain_d = otpc_pkg::GAIN_MID;
            default: gain_d = otpc_pkg::GAIN_HIGH;
        endcase
        led_code = (f_led == otpc_pkg::LED_SPARE_CODE) ? otpc_pkg::LED_SPARE_MAP : f_led;
        sh_d[0] = {2'h0, f_mon};
        sh_d[1] = {2'h0, f_mon} + {2'h0, f_cal} + otpc_pkg::CAL_SH_OFS;
        sh_d[2] = {1'h0, led_code};
    end

    // Decoded fields change only on a load, never mid-run
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cfg_valid_q <= 1'b0;
            gain_o <= otpc_pkg::GAIN_HIGH;
            creep_sel_o <= otpc_pkg::DEF_CREEP;
            mon_rate_o <= '0;
            cal_mult_o <= '0;
            led_rate_o <= '0;
            pulse_lev_o <= otpc_pkg::DEF_LEV;
            sh_q <= '{default: 4'h0};
        end else if (load_q) begin
            cfg_valid_q <= 1'b1;
            gain_o <= gain_d;
            creep_sel_o <= f_creep;
            mon_rate_o <= otpc_pkg::BASE_RATE << f_mon;
            cal_mult_o <= otpc_pkg::BASE_MULT << f_cal;
            led_rate_o <= otpc_pkg::BASE_RATE << led_code;
            pulse_lev_o <= f_lev;
            sh_q <= sh_d;
        end
    end
    assign cfg_valid_o = cfg_valid_q;
    assign program_data_pin_mode_o = (state_q == otpc_pkg::ST_PROGRAM_DATA_PIN_IDLE) ||
                         (state_q == otpc_pkg::ST_TW_ARMED) ||
                         (state_q == otpc_pkg::ST_TW_SHIFT);

    ////////////////////////////////////////////////////////////////////////
    logic [23:0] acc_q, acc_d, acc_sum;
    logic fast_pulse_q, fast_pulse_d;

    always_comb begin
        acc_sum = acc_q + (energy_valid_i ? 24'(energy_inc_i) : 24'h000000);
        acc_d = acc_q;
        fast_pulse_d = 1'b0;
        if (cfg_valid_q) begin
            acc_d = acc_sum;
            if (acc_sum > {2'h0, pulse_lev_o}) begin
                acc_d = acc_sum - {2'h0, pulse_lev_o};
                fast_pulse_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            acc_q <= 24'h000000;
            fast_pulse_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            fast_pulse_q <= fast_pulse_d;
        end
    end
    assign fast_pulse_o = fast_pulse_q;

    // Fast stream counts at 51200 per kWh; divide by 512 >> shift per output
    logic [2:0] out_pulse_q;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_div
            logic [9:0] div_q, div_d, div_top;
            logic out_d;
            always_comb begin
                div_top = (otpc_pkg::DIV_BASE >> sh_q[gi]) - 10'h001;
                div_d = div_q;
                out_d = 1'b0;
                if (fast_pulse_q) begin
                    if (div_q >= div_top) begin
                        div_d = 10'h000;
                        out_d = 1'b1;
                    end else begin
                        div_d = div_q + 10'h001;
                    end
                end
            end
            always_ff @(posedge sys_clk_i) begin
                if (!rst_n_i) begin
                    div_q <= 10'h000;
                    out_pulse_q[gi] <= 1'b0;
                end else begin
                    div_q <= div_d;
                    out_pulse_q[gi] <= out_d;
                end
            end
        end
    endgenerate
    // No mode gating, so the pulses stay visible while programming
    assign motor_drive_outputs_o = out_pulse_q[0];
    assign cal_pulse_o = out_pulse_q[1];
    assign led_pulse_o = out_pulse_q[2];

    ////////////////////////////////////////////////////////////////////////
    program_data_pin_sticky_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        program_data_pin_mode_o |=> program_data_pin_mode_o) else $error("left programming mode");
    normal_sticky_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        state_q == otpc_pkg::ST_NORMAL |=> state_q == otpc_pkg::ST_NORMAL)
        else $error("left normal mode");
    mode_pick_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (state_q == otpc_pkg::ST_READ && !pins.lvl[otpc_pkg::PIN_MODE])
        |=> state_q == otpc_pkg::ST_NORMAL ##1 load_q == 1'b0)
        else $error("low mode select did not give normal");
    fuse_keep_a: assert property (@(posedge sys_clk_i)
        fuse_blank_n_i |=> ((fuse_q & $past(fuse_q)) == $past(fuse_q)))
        else $error("a burned fuse cleared");
    tw_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (state_q == otpc_pkg::ST_TW_SHIFT && pins.rise[otpc_pkg::PIN_SCLK]
         && cnt_q == otpc_pkg::SHIFT_LAST)
        |=> state_q == otpc_pkg::ST_PROGRAM_DATA_PIN_IDLE && word_q == ~shift_q ##2 cfg_valid_o)
        else $error("test-write did not load inverted word");
    cfg_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !load_q |=> $stable(pulse_lev_o) && $stable(gain_o))
        else $error("config changed without a load");
    default_cfg_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (load_q && !word_q[otpc_pkg::SEL_BIT])
        |=> gain_o == otpc_pkg::GAIN_HIGH && pulse_lev_o == otpc_pkg::DEF_LEV
            && led_rate_o == 13'h0C80)
        else $error("defaults not applied");
    bank_pick_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (load_q && word_q[otpc_pkg::SEL_BIT] && word_q[otpc_pkg::BANK_BIT])
        |=> pulse_lev_o == $past(word_q[56:35]))
        else $error("bank 1 threshold not taken");
    fast_fire_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (cfg_valid_q && energy_valid_i && acc_sum > {2'h0, pulse_lev_o})
        |=> fast_pulse_o) else $error("threshold crossing gave no pulse");
    div_src_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (led_pulse_o || cal_pulse_o || motor_drive_outputs_o) |-> $past(fast_pulse_q))
        else $error("output pulse without fast pulse");
endmodule // otpc_config_loader

// ===== design/otpc_pkg.sv
// Constants for the power-up mode and fuse configuration loader.
// Assumes one 100 MHz system clock and a synchronous active-low power-on reset.
package otpc_pkg;
    localparam int WORD_W = 70;
    localparam int SEL_BIT = 0;
    localparam int BANK_BIT = 1;
    localparam int B0_LEV_LSB = 2;
    localparam int B0_LED_LSB = 24;
    localparam int B0_CAL_LSB = 27;
    localparam int B0_MON_LSB = 29;
    localparam int B0_CREEP_LSB = 31;
    localparam int B0_GAIN_LSB = 33;
    localparam int B1_LEV_LSB = 35;
    localparam int B1_LED_LSB = 57;
    localparam int B1_CAL_LSB = 60;
    localparam int B1_MON_LSB = 62;
    localparam int B1_CREEP_LSB = 64;
    localparam int B1_GAIN_LSB = 66;
    localparam int LEV_W = 22;
    localparam logic [1:0] DEF_GAIN = 2'h3;
    localparam logic [1:0] DEF_CREEP = 2'h1;
    localparam logic [1:0] DEF_MON = 2'h2;
    localparam logic [1:0] DEF_CAL = 2'h1;
    localparam logic [2:0] DEF_LED = 3'h5;
    localparam logic [21:0] DEF_LEV = 22'h06A6D4;
    localparam logic [2:0] LED_SPARE_CODE = 3'h7;
    localparam logic [2:0] LED_SPARE_MAP = 3'h6;
    localparam logic [4:0] GAIN_LOW = 5'h04;
    localparam logic [4:0] GAIN_MID = 5'h10;
    localparam logic [4:0] GAIN_HIGH = 5'h14;
    localparam logic [12:0] BASE_RATE = 13'h0064;
    localparam logic [6:0] BASE_MULT = 7'h08;
    localparam logic [3:0] CAL_SH_OFS = 4'h3;
    localparam logic [9:0] DIV_BASE = 10'h200;
    localparam logic [2:0] SETTLE_CYC = 3'h4;
    localparam logic [6:0] SHIFT_LAST = 7'h45;
    localparam logic [69:0] SHIFT_RST = {70{1'b1}};
    localparam int PIN_N = 4;
    localparam int PIN_MODE = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_DATA = 2;
    localparam int PIN_BURN = 3;

    typedef enum logic [2:0] {
        ST_SETTLE = 3'b000,
        ST_READ = 3'b001,
        ST_NORMAL = 3'b010,
        ST_PROGRAM_DATA_PIN_IDLE = 3'b011,
        ST_TW_ARMED = 3'b100,
        ST_TW_SHIFT = 3'b101
    } otpc_state_e;
endpackage

// ===== design/otpc_pin_if.sv
// Carries the raw programming pins and their synchronised levels and edges.
// Assumes every signal here lives on the system clock, except raw.
`timescale 1ns/1ps
interface otpc_pin_if #(parameter int N = 4);
    logic [N-1:0] raw;
    logic [N-1:0] lvl;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    modport sync_mp (input raw, output lvl, output rise, output fall);
    modport core_mp (output raw, input lvl, input rise, input fall);
endinterface

// ===== design/otpc_pin_sync.sv
// Two-stage synchronisers with edge detection for the programming pins.
// Assumes raw pins are asynchronous to sys_clk_i.
`timescale 1ns/1ps
module otpc_pin_sync #(
    parameter int N = 4
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    otpc_pin_if.sync_mp pins
);
    logic [N-1:0] meta_q;
    logic [N-1:0] sync_q;
    logic [N-1:0] last_q;
    logic [N-1:0] meta_d;
    logic [N-1:0] sync_d;
    logic [N-1:0] last_d;

    if (N < 1) begin : g_bad_n
        $error("otpc_pin_sync needs at least one pin");
    end

    always_comb begin
        meta_d = pins.raw;
        sync_d = meta_q;
        last_d = sync_q;
    end

    // Edges compare stages two and three; stage one feeds nothing else
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
            last_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            last_q <= last_d;
        end
    end

    assign pins.lvl = sync_q;
    assign pins.rise = sync_q & ~last_q;
    assign pins.fall = ~sync_q & last_q;
endmodule // otpc_pin_sync

// ===== tb/otpc_program_data_pin_model.sv
// Programming station model: drives the mode select, shift clock and data pins.
// Assumes the loader samples all three pins through its own synchronisers.
`timescale 1ns/1ps
module otpc_program_data_pin_model (
    output logic mode_o,
    output logic sclk_o,
    output logic data_o
);
    // Mode and clock start levels come only from set_power_up, so time zero has no race
    initial begin
        data_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Levels held through power-up pick the mode
    task automatic set_power_up(input logic mode, input logic clk);
        mode_o = mode;
        sclk_o = clk;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Inverse word, MSB first; data moves 25 ns after a rise, so setup is 100 ns
    task automatic test_write(input logic [69:0] word);
        logic [69:0] inv;
        inv = ~word;
        mode_o = 1'b0;
        #100;
        mode_o = 1'b1;
        data_o = inv[69];
        // Odd offset keeps every later shift clock and data change off the system clock edges
        #102.5;
        for (int i = 69; i >= 0; i--) begin
            sclk_o = 1'b1;
            #25;
            // After the frame the line no longer holds the last bit
            data_o = (i > 0) ? inv[i-1] : ~inv[0];
            #35;
            sclk_o = 1'b0;
            #65;
        end
    endtask
endmodule // otpc_program_data_pin_model

// ===== tb/tb.sv
// Self-checking bench for the fuse configuration loader.
// Assumes the station model on the pins and a 100 MHz clock.
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [1:0] g;
        logic [1:0] a;
        logic [1:0] m;
        logic [1:0] c;
        logic [2:0] l;
        logic [21:0] lev;
        logic bank;
        logic sel;
        logic [4:0] eg;
        logic [1:0] ea;
        logic [12:0] em;
        logic [6:0] ec;
        logic [12:0] el;
        logic [21:0] elev;
    } otpc_row_s;

    // Row 7 has the use-programmed bit clear, so it expects the hard defaults
    localparam otpc_row_s ROWS [9] = '{
        '{0, 0, 0, 0, 0, 22'h000001, 0, 1, 5'h04, 0, 13'h0064, 7'h08, 13'h0064, 22'h000001},
        '{1, 1, 1, 1, 1, 22'h3FFFFF, 1, 1, 5'h10, 1, 13'h00C8, 7'h10, 13'h00C8, 22'h3FFFFF},
        '{2, 2, 2, 2, 2, 22'h155555, 0, 1, 5'h10, 2, 13'h0190, 7'h20, 13'h0190, 22'h155555},
        '{3, 3, 3, 3, 3, 22'h2AAAAA, 1, 1, 5'h14, 3, 13'h0320, 7'h40, 13'h0320, 22'h2AAAAA},
        '{0, 1, 2, 3, 4, 22'h06A6D4, 0, 1, 5'h04, 1, 13'h0190, 7'h40, 13'h0640, 22'h06A6D4},
        '{1, 2, 3, 0, 5, 22'h000100, 1, 1, 5'h10, 2, 13'h0320, 7'h08, 13'h0C80, 22'h000100},
        '{2, 3, 0, 1, 7, 22'h123456, 1, 1, 5'h10, 3, 13'h0064, 7'h10, 13'h1900, 22'h123456},
        '{3, 0, 1, 2, 6, 22'h0ABCDE, 0, 0, 5'h14, 1, 13'h0190, 7'h10, 13'h0C80, 22'h06A6D4},
        '{3, 0, 3, 3, 6, 22'h00000A, 0, 1, 5'h14, 0, 13'h0320, 7'h40, 13'h1900, 22'h00000A}
    };

    logic sys_clk_i;
    logic rst_n_i;
    logic fuse_blank_n_i;
    logic mode_pin;
    logic sclk_pin;
    logic data_pin;
    logic burn_strobe_i;
    logic energy_valid_i;
    logic [15:0] energy_inc_i;
    logic program_data_pin_mode_o;
    logic cfg_valid_o;
    logic [4:0] gain_o;
    logic [1:0] creep_sel_o;
    logic [12:0] mon_rate_o;
    logic [6:0] cal_mult_o;
    logic [12:0] led_rate_o;
    logic [21:0] pulse_lev_o;
    logic fast_pulse_o;
    logic motor_drive_outputs_o;
    logic cal_pulse_o;
    logic led_pulse_o;
    logic counting;
    logic [15:0] n_fast;
    logic [15:0] n_mon;
    logic [15:0] n_cal;
    logic [15:0] n_led;
    int n_mismatch;
    int comparisons;

    otpc_program_data_pin_model partner (.mode_o(mode_pin), .sclk_o(sclk_pin), .data_o(data_pin));

    otpc_config_loader #(.ENERGY_W(16)) dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .fuse_blank_n_i(fuse_blank_n_i),
        .power_up_mode_select_i(mode_pin), .direction_out_shift_clock_i(sclk_pin),
        .program_data_pin_i(data_pin), .burn_strobe_i(burn_strobe_i),
        .energy_valid_i(energy_valid_i), .energy_inc_i(energy_inc_i),
        .program_data_pin_mode_o(program_data_pin_mode_o), .cfg_valid_o(cfg_valid_o), .gain_o(gain_o),
        .creep_sel_o(creep_sel_o), .mon_rate_o(mon_rate_o), .cal_mult_o(cal_mult_o),
        .led_rate_o(led_rate_o), .pulse_lev_o(pulse_lev_o), .fast_pulse_o(fast_pulse_o),
        .motor_drive_outputs_o(motor_drive_outputs_o), .cal_pulse_o(cal_pulse_o),
        .led_pulse_o(led_pulse_o));

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        if (counting === 1'b1) begin
            n_fast <= n_fast + 16'(fast_pulse_o === 1'b1);
            n_mon <= n_mon + 16'(motor_drive_outputs_o === 1'b1);
            n_cal <= n_cal + 16'(cal_pulse_o === 1'b1);
            n_led <= n_led + 16'(led_pulse_o === 1'b1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Other bank left all zero, as a station would send it
    function automatic logic [69:0] make_word(input otpc_row_s r);
        logic [69:0] w;
        int o;
        w = '0;
        o = r.bank ? (otpc_pkg::B1_GAIN_LSB - otpc_pkg::B0_GAIN_LSB) : 0;
        w[otpc_pkg::B0_GAIN_LSB + o +: 2] = r.g;
        w[otpc_pkg::B0_CREEP_LSB + o +: 2] = r.a;
        w[otpc_pkg::B0_MON_LSB + o +: 2] = r.m;
        w[otpc_pkg::B0_CAL_LSB + o +: 2] = r.c;
        w[otpc_pkg::B0_LED_LSB + o +: 3] = r.l;
        w[otpc_pkg::B0_LEV_LSB + o +: 22] = r.lev;
        w[otpc_pkg::BANK_BIT] = r.bank;
        w[otpc_pkg::SEL_BIT] = r.sel;
        return w;
    endfunction

    task automatic check_cfg(input otpc_row_s r);
        comparisons++;
        if (gain_o !== r.eg || creep_sel_o !== r.ea || mon_rate_o !== r.em ||
            cal_mult_o !== r.ec || led_rate_o !== r.el || pulse_lev_o !== r.elev ||
            cfg_valid_o !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: config gain %0d rate %0d", $time, gain_o, mon_rate_o);
        end
    endtask

    task automatic check_val(input logic [21:0] act, input logic [21:0] exp, input string what);
        comparisons++;
        if (act !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %0h", $time, what, act);
        end
    endtask

    task automatic power_cycle(input logic mode, input logic clk);
        @(negedge sys_clk_i);
        rst_n_i = 1'b0;
        partner.set_power_up(mode, clk);
        repeat (16) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        repeat (20) @(negedge sys_clk_i);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #300us;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        n_mismatch = 0;
        comparisons = 0;
        counting = 1'b0;
        n_fast = '0;
        n_mon = '0;
        n_cal = '0;
        n_led = '0;
        rst_n_i = 1'b0;
        fuse_blank_n_i = 1'b0;
        burn_strobe_i = 1'b0;
        energy_valid_i = 1'b0;
        energy_inc_i = 16'h0000;
        partner.set_power_up(1'b1, 1'b0);
        repeat (16) @(negedge sys_clk_i);
        check_val(22'(gain_o), 22'h14, "reset gain");
        check_val(22'(creep_sel_o), 22'h1, "reset creep");
        check_val(pulse_lev_o, 22'h06A6D4, "reset level");
        check_val(22'(cfg_valid_o), 22'h0, "reset valid");
        fuse_blank_n_i = 1'b1;
        rst_n_i = 1'b1;
        repeat (20) @(negedge sys_clk_i);
        check_val(22'(program_data_pin_mode_o), 22'h1, "program_data_pin entry");
        check_cfg(ROWS[7]);
        $display("test power-up done");
        for (int i = 0; i < 9; i++) begin
            partner.test_write(make_word(ROWS[i]));
            repeat (10) @(negedge sys_clk_i);
            check_cfg(ROWS[i]);
            check_val(22'(program_data_pin_mode_o), 22'h1, "program_data_pin hold");
        end
        $display("test rows done");
        // Level 10 with steps of 10 fires on every step after the first
        counting = 1'b1;
        energy_valid_i = 1'b1;
        energy_inc_i = 16'h000A;
        repeat (513) @(negedge sys_clk_i);
        energy_valid_i = 1'b0;
        energy_inc_i = 16'h0000;
        repeat (10) @(negedge sys_clk_i);
        counting = 1'b0;
        check_val(22'(n_fast), 22'h000200, "fast count");
        check_val(22'(n_cal), 22'h000200, "cal count");
        check_val(22'(n_led), 22'h000040, "led count");
        check_val(22'(n_mon), 22'h000008, "motor count");
        $display("test pulses done");
        burn_strobe_i = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        burn_strobe_i = 1'b0;
        repeat (10) @(negedge sys_clk_i);
        power_cycle(1'b0, 1'b0);
        check_val(22'(program_data_pin_mode_o), 22'h0, "normal entry");
        check_cfg(ROWS[8]);
        partner.test_write(make_word(ROWS[0]));
        repeat (10) @(negedge sys_clk_i);
        check_cfg(ROWS[8]);
        $display("test burn done");
        power_cycle(1'b1, 1'b0);
        partner.test_write(make_word(ROWS[1]));
        repeat (10) @(negedge sys_clk_i);
        check_cfg(ROWS[1]);
        power_cycle(1'b0, 1'b0);
        check_cfg(ROWS[8]);
        $display("test volatile done");
        // Mode select high but shift clock high at power-up is still normal
        power_cycle(1'b1, 1'b1);
        check_val(22'(program_data_pin_mode_o), 22'h0, "clock high entry");
        check_cfg(ROWS[8]);
        $display("test clock-high power-up done");
        report_and_stop();
    end
endmodule // tb
